// File: inc/sar_pkg.sv
// constants and types shared by the sar sequencer and its engine
`default_nettype none
package sar_pkg;
  // conversion clock derived from the core clock, never above its limit
  localparam int CORE_CLK_HZ = 50_000_000;
  localparam int CONV_CLK_MAX_HZ = 18_000_000;
  localparam int CONV_DIV = (CORE_CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
  localparam int DIV_W = $clog2(CONV_DIV);
  localparam int RES_W = 12;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int SAMPLE_W = 8;
  localparam int MIN_CONV_TICKS = 18;
  localparam int MIN_SAMPLE_TICKS = MIN_CONV_TICKS - RES_W;

  // register byte offsets
  localparam logic [6:0] OFF_CTRL = 7'h00;
  localparam logic [6:0] OFF_CHEN = 7'h04;
  localparam logic [6:0] OFF_APER = 7'h08;
  localparam logic [6:0] OFF_LIMLO = 7'h0c;
  localparam logic [6:0] OFF_LIMHI = 7'h10;
  localparam logic [6:0] OFF_INTSTAT = 7'h14;
  localparam logic [6:0] OFF_INTMASK = 7'h18;
  localparam logic [6:0] OFF_STATUS = 7'h1c;
  localparam logic [6:0] OFF_SAMPLE = 7'h20;
  localparam logic [6:0] OFF_RESULT = 7'h40;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FW_BIT = 1;
  localparam int CTRL_FWCH_LSB = 4;
  localparam int INT_W = 3;
  localparam int INT_EOC_BIT = 0;
  localparam int INT_RANGE_BIT = 1;
  localparam int INT_SCAN_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  localparam int STAT_CH_LSB = 4;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [NUM_CH-1:0] CHEN_RST = 8'h01;
  localparam logic [SAMPLE_W-1:0] APER_RST = 8'h00;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 8'h00;
  localparam logic [RES_W-1:0] LIMLO_RST = 12'h000;
  localparam logic [RES_W-1:0] LIMHI_RST = 12'hfff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV = 3'b100
  } eng_state_t;
endpackage
`default_nettype wire

// File: inc/conv_if.sv
// request and result path between the sequencer and the engine
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
  import sar_pkg::*;
  logic tick;
  logic req;
  logic halt;
  logic [CH_W-1:0] chan;
  logic [SAMPLE_W:0] sampleLen;
  logic ack;
  logic busy;
  logic done;
  logic [CH_W-1:0] doneChan;
  logic [RES_W-1:0] result;
  modport seq (output tick, req, halt, chan, sampleLen,
               input ack, busy, done, doneChan, result);
  modport eng (input tick, req, halt, chan, sampleLen,
               output ack, busy, done, doneChan, result);
endinterface
`default_nettype wire

// File: rtl/sar_engine.sv
// successive-approximation engine: sample phase then one bit per tick
`timescale 1ns/1ps
`default_nettype none
module sar_engine (
  input wire logic clk,
  input wire logic rstn,
  conv_if.eng cv,
  output logic [sar_pkg::CH_W-1:0] muxSel,
  output logic sampleHold,
  output logic [sar_pkg::RES_W-1:0] dacCode,
  input wire logic cmpIn
);
  import sar_pkg::*;
  localparam logic [SAMPLE_W:0] MIN_SAMPLE = (SAMPLE_W+1)'(MIN_SAMPLE_TICKS);
  localparam logic [RES_W-1:0] MSB_ONE = {1'b1, {(RES_W-1){1'b0}}};
  localparam logic [SAMPLE_W:0] CNT_LAST = (SAMPLE_W+1)'(1);

  eng_state_t state_r;
  logic [SAMPLE_W:0] cnt_r;
  logic [RES_W-1:0] code_r;
  logic [RES_W-1:0] trial_r;
  logic [CH_W-1:0] chan_r;
  logic done_r;
  logic [RES_W-1:0] result_r;
  logic [CH_W-1:0] doneChan_r;
  logic lastBit;
  logic load;

  assign lastBit = (state_r == ST_CONV) && trial_r[0] && cv.tick;
  // R4: reload on the final bit tick
  assign load = cv.req && !cv.halt && cv.tick &&
                ((state_r == ST_IDLE) || lastBit);
  assign cv.ack = load;
  assign cv.busy = (state_r != ST_IDLE);
  assign cv.done = done_r;
  assign cv.result = result_r;
  assign cv.doneChan = doneChan_r;
  assign muxSel = chan_r;
  assign sampleHold = (state_r == ST_SAMPLE);
  assign dacCode = code_r | trial_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    // R10: sleep aborts any conversion
    end else if (cv.halt) begin
      state_r <= ST_IDLE;
    end else if (load) begin
      state_r <= ST_SAMPLE;
    end else if (cv.tick) begin
      case (state_r)
        ST_SAMPLE: if (cnt_r == CNT_LAST) state_r <= ST_CONV;
        ST_CONV: if (trial_r[0]) state_r <= ST_IDLE;
        ST_IDLE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      code_r <= '0;
      trial_r <= '0;
      chan_r <= '0;
    end else if (cv.halt) begin
      trial_r <= '0;
    end else if (load) begin
      // R1: sample phase padded so total reaches the minimum
      cnt_r <= (cv.sampleLen > MIN_SAMPLE) ? cv.sampleLen : MIN_SAMPLE;
      chan_r <= cv.chan;
      code_r <= '0;
      trial_r <= '0;
    end else if (cv.tick && (state_r == ST_SAMPLE)) begin
      cnt_r <= cnt_r - CNT_LAST;
      if (cnt_r == CNT_LAST) trial_r <= MSB_ONE;
    end else if (cv.tick && (state_r == ST_CONV)) begin
      if (cmpIn) code_r <= code_r | trial_r;
      trial_r <= trial_r >> 1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_r <= 1'b0;
      result_r <= '0;
      doneChan_r <= '0;
    end else begin
      done_r <= lastBit && !cv.halt;
      if (lastBit) begin
        result_r <= code_r | (cmpIn ? trial_r : '0);
        doneChan_r <= chan_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [9:0] ticks_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ticks_r <= '0;
    else if (load) ticks_r <= '0;
    else if (cv.tick && cv.busy) ticks_r <= ticks_r + 10'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_min_conv;
    lastBit |-> ticks_r >= 10'(MIN_CONV_TICKS - 1);
  endproperty
  a_min_conv: assert property (p_min_conv) // R1
    else $error("conversion shorter than the minimum");
  property p_no_gap;
    lastBit && cv.req && !cv.halt |=> state_r == ST_SAMPLE && sampleHold;
  endproperty
  a_no_gap: assert property (p_no_gap) // R4
    else $error("dead cycle between conversions");
  property p_halt;
    cv.halt |=> state_r == ST_IDLE && !done_r && !sampleHold;
  endproperty
  a_halt: assert property (p_halt) // R10
    else $error("conversion continued while halted");
  property p_done_chan;
    lastBit && !cv.halt |=> done_r && doneChan_r == $past(chan_r);
  endproperty
  a_done_chan: assert property (p_done_chan) // R6
    else $error("result not tagged with its channel");
  c_back_to_back: cover property (lastBit && load);
  c_halt_mid: cover property (cv.halt && state_r == ST_CONV);
endmodule
`default_nettype wire

// File: rtl/sar_seq_ctrl.sv
// sar adc sequencer control with axi4-lite registers
//
// Contract
// R1: conversion lasts at least 18 conversion clocks
// R2: conversion clock at most 18 MHz
// R3: scan eight channels without cpu help
// R4: channel switching adds no dead cycles
// R5: hardware or firmware selects the channel
// R6: separate result holding per channel
// R7: sample time programmable per channel
// R8: sample-and-hold window length programmable
// R9: out-of-range interrupt right after compare
// R10: no conversion in deepest sleep mode
// R11: range flag sticky until software clears
`timescale 1ns/1ps
`default_nettype none
module sar_seq_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic deepSleep,
  output logic irq,
  output logic [sar_pkg::CH_W-1:0] muxSel,
  output logic sampleHold,
  output logic [sar_pkg::RES_W-1:0] dacCode,
  input wire logic cmpIn
);
  import sar_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rstMeta_r;
  logic rstSync;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_r <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync <= rstMeta_r;
    end
  end

  // ---------------------------------------------------------------
  // conversion clock enable
  // ---------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);
  logic [DIV_W-1:0] div_r;
  logic tick;
  // R2: one tick every third core cycle
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) div_r <= '0;
    else if (div_r == DIV_LAST) div_r <= '0;
    else div_r <= div_r + DIV_W'(1);
  end
  assign tick = (div_r == DIV_LAST);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [NUM_CH-1:0] chen_r;
  logic [SAMPLE_W-1:0] aper_r;
  logic [RES_W-1:0] limLo_r;
  logic [RES_W-1:0] limHi_r;
  logic [INT_W-1:0] intStat_r;
  logic [INT_W-1:0] intMask_r;
  logic [SAMPLE_W-1:0] sample_r [NUM_CH];
  logic [RES_W-1:0] result_r [NUM_CH];
  logic [CH_W-1:0] lastChan_r;

  conv_if cv ();

  sar_engine u_engine (
    .clk(core_clk),
    .rstn(rstSync),
    .cv(cv.eng),
    .muxSel(muxSel),
    .sampleHold(sampleHold),
    .dacCode(dacCode),
    .cmpIn(cmpIn)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // next enabled channel after cur, wrapping; cur when none other
  function automatic logic [CH_W-1:0] nextCh(
    input logic [NUM_CH-1:0] m,
    input logic [CH_W-1:0] cur
  );
    logic [CH_W-1:0] idx;
    logic found;
    nextCh = cur;
    found = 1'b0;
    for (int i = 1; i <= NUM_CH; i++) begin
      idx = cur + CH_W'(i);
      if (m[idx] && !found) begin
        nextCh = idx;
        found = 1'b1;
      end
    end
  endfunction

  logic enable;
  logic fwMode;
  logic [CH_W-1:0] fwChan;
  logic [CH_W-1:0] chanOffer;
  logic outRange;
  logic scanEnd;
  logic [INT_W-1:0] intSet;

  assign enable = ctrl_r[CTRL_EN_BIT];
  assign fwMode = ctrl_r[CTRL_FW_BIT];
  assign fwChan = ctrl_r[CTRL_FWCH_LSB +: CH_W];
  // R5: firmware channel overrides the scan
  // R3: otherwise step to the next enabled channel
  assign chanOffer = fwMode ? fwChan : nextCh(chen_r, lastChan_r);
  assign cv.tick = tick;
  // R10: no requests while the fast clock is gone
  assign cv.req = enable && !deepSleep && (fwMode || (|chen_r));
  assign cv.halt = deepSleep || !enable;
  assign cv.chan = chanOffer;
  // R7: per-channel sample time
  // R8: plus the common hold aperture
  assign cv.sampleLen = {1'b0, sample_r[chanOffer]} + {1'b0, aper_r};

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) lastChan_r <= CH_W'(NUM_CH - 1);
    else if (cv.ack) lastChan_r <= chanOffer;
  end

  // R9: compare each result as it lands
  assign outRange = cv.done &&
                    ((cv.result < limLo_r) || (cv.result > limHi_r));
  assign scanEnd = cv.done && !fwMode &&
                   (nextCh(chen_r, cv.doneChan) <= cv.doneChan);
  always_comb begin
    intSet = '0;
    intSet[INT_EOC_BIT] = cv.done;
    intSet[INT_RANGE_BIT] = outRange;
    intSet[INT_SCAN_BIT] = scanEnd;
  end

  // R6: one result slot per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
          result_r[g] <= '0;
        end else if (cv.done && (cv.doneChan == CH_W'(g))) begin
          result_r[g] <= cv.result;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  logic awHeld_r;
  logic wHeld_r;
  logic [31:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic doWrite;
  logic wrOk;
  logic [6:0] wOff;
  logic [31:0] wMask;
  logic [31:0] wVal;

  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready = !wHeld_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
  assign wOff = awAddr_r[6:0];

  always_comb begin
    wMask = '0;
    for (int i = 0; i < 4; i++) begin
      wMask[i*8 +: 8] = {8{wStrb_r[i]}};
    end
    wVal = wData_r & wMask;
    wrOk = (awAddr_r[31:7] == '0) && (wOff[1:0] == 2'h0);
    case (wOff)
      OFF_CTRL, OFF_CHEN, OFF_APER, OFF_LIMLO: wrOk = wrOk;
      OFF_LIMHI, OFF_INTSTAT, OFF_INTMASK: wrOk = wrOk;
      default: wrOk = wrOk && (wOff[6:5] == OFF_SAMPLE[6:5]);
    endcase
  end

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
      if (doWrite) begin
        bvalid_r <= 1'b1;
        bresp_r <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  logic wrCfg;
  assign wrCfg = doWrite && wrOk;

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      ctrl_r <= CTRL_RST;
      chen_r <= CHEN_RST;
      aper_r <= APER_RST;
      limLo_r <= LIMLO_RST;
      limHi_r <= LIMHI_RST;
      intMask_r <= '0;
    end else if (wrCfg) begin
      case (wOff)
        OFF_CTRL: ctrl_r <= (ctrl_r & ~wMask[7:0]) | wVal[7:0];
        OFF_CHEN: chen_r <= (chen_r & ~wMask[NUM_CH-1:0]) |
                            wVal[NUM_CH-1:0];
        OFF_APER: aper_r <= (aper_r & ~wMask[SAMPLE_W-1:0]) |
                            wVal[SAMPLE_W-1:0];
        OFF_LIMLO: limLo_r <= (limLo_r & ~wMask[RES_W-1:0]) |
                              wVal[RES_W-1:0];
        OFF_LIMHI: limHi_r <= (limHi_r & ~wMask[RES_W-1:0]) |
                              wVal[RES_W-1:0];
        OFF_INTMASK: intMask_r <= (intMask_r & ~wMask[INT_W-1:0]) |
                                  wVal[INT_W-1:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_smp
      always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
          sample_r[g] <= SAMPLE_RST;
        end else if (wrCfg && (wOff == OFF_SAMPLE + 7'(4 * g))) begin
          sample_r[g] <= (sample_r[g] & ~wMask[SAMPLE_W-1:0]) |
                         wVal[SAMPLE_W-1:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  logic [INT_W-1:0] intClr;
  assign intClr = (wrCfg && (wOff == OFF_INTSTAT)) ? wVal[INT_W-1:0] : '0;
  // R11: write one clears, a new event wins
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) intStat_r <= '0;
    else intStat_r <= (intStat_r & ~intClr) | intSet;
  end
  // R9: level interrupt from unmasked status
  assign irq = |(intStat_r & intMask_r);

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rdNxt;
  logic rdOk;
  logic [6:0] rOff;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rOff = s_axi_araddr[6:0];

  always_comb begin
    rdNxt = '0;
    rdOk = (s_axi_araddr[31:7] == '0) && (rOff[1:0] == 2'h0);
    case (rOff)
      OFF_CTRL: rdNxt[7:0] = ctrl_r;
      OFF_CHEN: rdNxt[NUM_CH-1:0] = chen_r;
      OFF_APER: rdNxt[SAMPLE_W-1:0] = aper_r;
      OFF_LIMLO: rdNxt[RES_W-1:0] = limLo_r;
      OFF_LIMHI: rdNxt[RES_W-1:0] = limHi_r;
      OFF_INTSTAT: rdNxt[INT_W-1:0] = intStat_r;
      OFF_INTMASK: rdNxt[INT_W-1:0] = intMask_r;
      OFF_STATUS: begin
        rdNxt[STAT_BUSY_BIT] = cv.busy;
        rdNxt[STAT_SLEEP_BIT] = deepSleep;
        rdNxt[STAT_CH_LSB +: CH_W] = lastChan_r;
      end
      default: begin
        if (rOff[6:5] == OFF_SAMPLE[6:5]) begin
          rdNxt[SAMPLE_W-1:0] = sample_r[rOff[4:2]];
        end else if (rOff[6:5] == OFF_RESULT[6:5]) begin
          rdNxt[RES_W-1:0] = result_r[rOff[4:2]];
        end else begin
          rdOk = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rdOk ? rdNxt : '0;
      rresp_r <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync);

  property p_tick_rate;
    tick |-> ##1 (!tick)[*2] ##1 tick;
  endproperty
  a_tick_rate: assert property (p_tick_rate) // R2
    else $error("conversion clock too fast");
  property p_scan_enabled;
    cv.ack && !fwMode |-> chen_r[chanOffer];
  endproperty
  a_scan_enabled: assert property (p_scan_enabled) // R3
    else $error("scan picked a disabled channel");
  property p_fw_chan;
    cv.ack && fwMode |=> muxSel == $past(fwChan);
  endproperty
  a_fw_chan: assert property (p_fw_chan) // R5
    else $error("firmware channel not applied");
  property p_result_slot;
    cv.done |=> result_r[$past(cv.doneChan)] == $past(cv.result);
  endproperty
  a_result_slot: assert property (p_result_slot) // R6
    else $error("result not stored in its channel slot");
  property p_range_irq;
    outRange |=> intStat_r[INT_RANGE_BIT];
  endproperty
  a_range_irq: assert property (p_range_irq) // R9
    else $error("out-of-range flag not raised");
  property p_range_sticky;
    intStat_r[INT_RANGE_BIT] && !intClr[INT_RANGE_BIT]
      |=> intStat_r[INT_RANGE_BIT];
  endproperty
  a_range_sticky: assert property (p_range_sticky) // R11
    else $error("range flag dropped without a clear");
  property p_sleep_idle;
    deepSleep |-> !cv.req ##1 !sampleHold;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) // R10
    else $error("conversion active in deep sleep");
  c_range: cover property (outRange && intMask_r[INT_RANGE_BIT]);
  c_scan_end: cover property (scanEnd);
  c_fw: cover property (cv.ack && fwMode);
endmodule
`default_nettype wire

// File: tb/analog_src.sv
// analog input model standing behind the channel multiplexer
`timescale 1ns/1ps
`default_nettype none
module analog_src (
  input wire logic core_clk,
  input wire logic [sar_pkg::CH_W-1:0] muxSel,
  input wire logic sampleHold,
  input wire logic [sar_pkg::RES_W-1:0] dacCode,
  output logic cmpIn
);
  import sar_pkg::*;
  logic [RES_W-1:0] vin [NUM_CH];
  logic [RES_W-1:0] held_r;
  always_ff @(posedge core_clk) begin
    if (sampleHold) held_r <= vin[muxSel];
  end
  // no valid answer while tracking, so it flips
  always_comb cmpIn = sampleHold ? ~held_r[0] : (held_r >= dacCode);
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the sar sequencer control
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sar_pkg::*;
  logic core_clk, rstn, deepSleep, irq, sampleHold, cmpIn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [CH_W-1:0] muxSel;
  logic [RES_W-1:0] dacCode;
  logic [31:0] rd;
  int err_total, num_checks;
  sar_seq_ctrl DUT (.*);
  analog_src partner (.*);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] got, input logic [31:0] e);
    num_checks++;
    if (got !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, got);
    end
  endtask
  // handshakes judged at the falling edge, acted on at the next rise
  task wr(input logic [6:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge core_clk);
    s_axi_awaddr <= 32'(a);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge core_clk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge core_clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!hb);
    s_axi_bready <= 1'b0;
  endtask
  task rc(input logic [6:0] a, input logic [31:0] e);
    logic ha, hb;
    @(posedge core_clk);
    s_axi_araddr <= 32'(a);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge core_clk);
      ha = s_axi_arvalid & s_axi_arready;
      hb = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge core_clk);
      if (ha) s_axi_arvalid <= 1'b0;
    end while (!hb);
    s_axi_rready <= 1'b0;
    chk("read data", rd, e);
  endtask
  task waitirq;
    int p;
    p = 0;
    while (irq !== 1'b1 && p < 600) begin
      @(negedge core_clk);
      p++;
    end
    chk("irq", 32'(irq), 32'h1);
  endtask
  // sample length and start-to-start spacing of channel ch
  task meas(input logic [2:0] ch, input int sh, input int per);
    int n, p;
    logic pv;
    n = 0;
    p = 0;
    pv = 1'b1;
    while (!(sampleHold && !pv && muxSel === ch) && p < 3000) begin
      pv = sampleHold;
      @(negedge core_clk);
      p++;
    end
    p = 0;
    while (sampleHold === 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    p = n;
    while (sampleHold !== 1'b1 && p < 3000) begin
      @(negedge core_clk);
      p++;
    end
    chk("sample cycles", n, sh);
    chk("conv spacing", p, per);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rc(OFF_CHEN, 32'(CHEN_RST));
    rc(OFF_LIMHI, 32'(LIMHI_RST));
    rc(7'h60, 32'h0);
    chk("unmapped resp", 32'(rsp), 32'(RESP_SLVERR));
    wr(OFF_RESULT, 32'h5);
    chk("ro resp", 32'(rsp), 32'(RESP_SLVERR));
    $display("regs test done");
  endtask
  task t_scan;
    wr(OFF_SAMPLE + 7'h08, 32'd10);
    wr(OFF_APER, 32'd2);
    wr(OFF_CHEN, 32'h07);
    wr(OFF_INTMASK, 32'h4);
    wr(OFF_CTRL, 32'h1);
    meas(3'd0, 18, 54);
    meas(3'd2, 36, 72);
    waitirq();
    wr(OFF_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      rc(OFF_RESULT + 7'(4 * i), 32'(partner.vin[i]));
    end
    wr(OFF_INTSTAT, 32'h7);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("scan test done");
  endtask
  task t_range;
    wr(OFF_LIMHI, 32'h200);
    wr(OFF_INTMASK, 32'h2);
    wr(OFF_CHEN, 32'h02);
    wr(OFF_CTRL, 32'h1);
    waitirq();
    // limits opened again: the flag must now hold with no new violation
    wr(OFF_LIMHI, 32'hfff);
    repeat (120) @(posedge core_clk);
    chk("irq sticky", 32'(irq), 32'h1);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_INTSTAT, 32'h2);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("range test done");
  endtask
  task t_fw;
    wr(OFF_CTRL, 32'h53);
    meas(3'd5, 18, 54);
    wr(OFF_CTRL, 32'h0);
    rc(OFF_RESULT + 7'h14, 32'(partner.vin[5]));
    $display("firmware test done");
  endtask
  task t_sleep;
    int n;
    n = 0;
    deepSleep <= 1'b1;
    wr(OFF_CTRL, 32'h1);
    repeat (150) begin
      @(negedge core_clk);
      if (sampleHold !== 1'b0) n++;
    end
    chk("sleep sampling", n, 0);
    // last channel issued is still the firmware pick, channel 5
    rc(OFF_STATUS, 32'h52);
    wr(OFF_CTRL, 32'h0);
    deepSleep <= 1'b0;
    $display("sleep test done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
  initial begin
    rstn = 1'b0;
    deepSleep = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      partner.vin[i] = 12'(12'h123 + 12'h1d0 * i);
    end
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_scan();
    t_range();
    t_fw();
    t_sleep();
    end_sim();
  end
endmodule
`default_nettype wire
